/* File: hdl/ring_io_bus_master.sv */
// Purpose: master of a serial ring i/o bus acting as one shift register
// Assumes: ring pins synchronous to clk; slaves handle their own portion
// Notes: rx is sampled mid-bit; returned stream aligned to tx frame
`timescale 1ns/1ps
module ring_io_bus_master
	import ring_master_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        runMode,
	input  wire logic [8:0]  numWords,
	input  wire word_wr_t    wordWr,
	input  wire logic [7:0]  inRdAddr,
	output logic [15:0]      inRdData,
	output logic             ring_tx_pos,
	output logic             ring_tx_neg,
	input  wire logic        ring_rx_pos,
	input  wire logic        ring_rx_neg,
	output logic             cycleDone,
	output logic             crcError,
	output logic             fallbackActive
);
	logic [15:0] outMem      [MAX_WORDS];
	logic [15:0] fallbackMem [MAX_WORDS];
	logic [15:0] inMem       [MAX_WORDS];
	logic [15:0] stageMem    [MAX_WORDS];

	ring_state_t state_reg;
	logic [7:0]  bitTimer_reg;
	logic [3:0]  bitIdx_reg;
	logic [8:0]  wordIdx_reg;
	logic [15:0] txShift_reg;
	logic [15:0] rxShift_reg;
	logic [15:0] txCrc_reg;
	logic [15:0] rxCrc_reg;
	logic        runPrev_reg;
	logic        fbPending_reg;
	logic        useFb_reg;
	logic        commit_reg;
	logic [8:0]  commitIdx_reg;
	logic        bitTick;
	logic        midTick;
	logic        rxBit;
	logic        txBit;

	function automatic logic [15:0] crcStep(input logic [15:0] c,
		input logic b);
		crcStep = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
	endfunction : crcStep

	// bit timing fixed by the master clock divider
	assign bitTick = (bitTimer_reg == 8'(BIT_CYCLES - 1));
	assign midTick = (bitTimer_reg == 8'(BIT_CYCLES / 2));
	// receive pair is differential; a one needs the true line high and the complement low
	assign rxBit = ring_rx_pos & ~ring_rx_neg;
	assign txBit = (state_reg == ST_CRC) ? txCrc_reg[15] : txShift_reg[15];

	// bit timer free runs so frames stay on a fixed bit grid
	always_ff @(posedge clk)
	begin
		if (srst || bitTick)
			bitTimer_reg <= 8'h00;
		else
			bitTimer_reg <= bitTimer_reg + 8'h01;
	end

	// host writes of output and fallback images
	always_ff @(posedge clk)
	begin
		if (wordWr.wr && wordWr.fallback)
			fallbackMem[wordWr.addr] <= wordWr.data;
		else if (wordWr.wr)
			outMem[wordWr.addr] <= wordWr.data;
	end

	// run to stop edge arms one fallback frame
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			runPrev_reg   <= 1'b0;
			fbPending_reg <= 1'b0;
		end
		else
		begin
			runPrev_reg <= runMode;
			// set beats the clear taken at frame start
			if (runPrev_reg && !runMode)
				fbPending_reg <= 1'b1;
			else if (state_reg == ST_IDLE && bitTick)
				fbPending_reg <= 1'b0;
		end
	end

	// frame sequencer: every cycle the master sends the whole stream
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_reg   <= ST_IDLE;
			bitIdx_reg  <= 4'h0;
			wordIdx_reg <= 9'h000;
			txShift_reg <= 16'h0000;
			txCrc_reg   <= CRC_INIT;
			useFb_reg   <= 1'b0;
		end
		else if (bitTick)
		begin
			case (state_reg)
				ST_IDLE:
				begin
					if ((runMode || fbPending_reg) && numWords != 9'h000)
					begin
						useFb_reg   <= fbPending_reg && !runMode;
						txShift_reg <= (fbPending_reg && !runMode) ?
							fallbackMem[8'h00] : outMem[8'h00];
						txCrc_reg   <= CRC_INIT;
						bitIdx_reg  <= 4'h0;
						wordIdx_reg <= 9'h000;
						state_reg   <= ST_DATA;
					end
				end
				ST_DATA:
				begin
					txCrc_reg  <= crcStep(txCrc_reg, txBit);
					bitIdx_reg <= bitIdx_reg + 4'h1;
					if (bitIdx_reg == LAST_BIT)
					begin
						// word order follows ring position, word 0 first
						wordIdx_reg <= wordIdx_reg + 9'h001;
						if (wordIdx_reg + 9'h001 >= numWords)
							state_reg <= ST_CRC;
						else
							txShift_reg <= useFb_reg ?
								fallbackMem[8'(wordIdx_reg + 9'h001)] :
								outMem[8'(wordIdx_reg + 9'h001)];
					end
					else
						txShift_reg <= {txShift_reg[14:0], 1'b0};
				end
				ST_CRC:
				begin
					txCrc_reg  <= {txCrc_reg[14:0], 1'b0};
					bitIdx_reg <= bitIdx_reg + 4'h1;
					if (bitIdx_reg == LAST_BIT)
						state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// returned stream sampled mid-bit into a staging image
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rxShift_reg   <= 16'h0000;
			rxCrc_reg     <= CRC_INIT;
			commit_reg    <= 1'b0;
			commitIdx_reg <= 9'h000;
		end
		else
		begin
			if (midTick && state_reg == ST_DATA)
			begin
				rxShift_reg <= {rxShift_reg[14:0], rxBit};
				rxCrc_reg   <= crcStep(rxCrc_reg, rxBit);
				if (bitIdx_reg == LAST_BIT)
					stageMem[8'(wordIdx_reg)] <= {rxShift_reg[14:0], rxBit};
			end
			else if (midTick && state_reg == ST_CRC)
				rxCrc_reg <= crcStep(rxCrc_reg, rxBit);
			else if (state_reg == ST_IDLE && bitTick)
				rxCrc_reg <= CRC_INIT;
			// residue zero once the received crc bits are folded in
			if (midTick && state_reg == ST_CRC && bitIdx_reg == LAST_BIT
				&& crcStep(rxCrc_reg, rxBit) == 16'h0000)
			begin
				commit_reg    <= 1'b1;
				commitIdx_reg <= 9'h000;
			end
			else if (commit_reg)
			begin
				commitIdx_reg <= commitIdx_reg + 9'h001;
				if (commitIdx_reg + 9'h001 >= numWords)
					commit_reg <= 1'b0;
			end
		end
	end

	// inputs copied only from a good frame; bad frame keeps old values
	always_ff @(posedge clk)
	begin
		if (commit_reg)
			inMem[8'(commitIdx_reg)] <= stageMem[8'(commitIdx_reg)];
		inRdData <= inMem[inRdAddr];
	end

	// registered pins and status
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ring_tx_pos    <= 1'b0;
			ring_tx_neg    <= 1'b1;
			cycleDone      <= 1'b0;
			crcError       <= 1'b0;
			fallbackActive <= 1'b0;
		end
		else
		begin
			ring_tx_pos    <= (state_reg == ST_IDLE) ? 1'b0 : txBit;
			ring_tx_neg    <= (state_reg == ST_IDLE) ? 1'b1 : ~txBit;
			cycleDone      <= midTick && state_reg == ST_CRC
				&& bitIdx_reg == LAST_BIT;
			fallbackActive <= useFb_reg && state_reg != ST_IDLE;
			if (midTick && state_reg == ST_CRC && bitIdx_reg == LAST_BIT)
				crcError <= (crcStep(rxCrc_reg, rxBit) != 16'h0000);
		end
	end
endmodule : ring_io_bus_master

/* File: hdl/ring_master_pkg.sv */
// Purpose: constants and types for the serial ring bus master
// Assumes: 100 MHz clock, 500 kbit/s ring, msb first, crc-16 ccitt poly
// Notes: frame = out words, then crc; returned stream = in words, then crc
// Notes on behaviour
// - sole master for up to 32 slaves
// - slave addresses 1..32 by ring position
// - slave next to master is address 1
// - ring acts as one shift register
// - master originates and shifts whole stream
// - stream returns to master, closing ring
// - bit rate fixed at 500 kbit/s
// - up to 256 in and out 16-bit words
// - crc-16 appended by sender, checked by receiver
// - full duplex, differential pairs both ways
// - run to stop sends fallback outputs
package ring_master_pkg;
	localparam int CLK_HZ       = 100_000_000;
	localparam int BIT_RATE     = 500_000;
	localparam int BIT_CYCLES   = CLK_HZ / BIT_RATE;
	localparam int MAX_SLAVES   = 32;
	localparam int MAX_WORDS    = 256;
	localparam int WORD_BITS    = 16;
	localparam int IDX_BITS     = 9;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [3:0]  LAST_BIT = 4'hf;

	typedef enum {ST_IDLE, ST_DATA, ST_CRC} ring_state_t;

	// host side word write port
	typedef struct packed {
		logic        wr;
		logic        fallback;
		logic [7:0]  addr;
		logic [15:0] data;
	} word_wr_t;
endpackage : ring_master_pkg

/* File: testbench/ring_chain_model.sv */
// Purpose: slave chain model on the far side of the ring
// Assumes: zero ring latency, slaves echo the outputs as inputs
// Notes: corrupt inverts the returned pair to break the crc
`timescale 1ns/1ps
module ring_chain_model
(
	input  wire logic txPos,
	input  wire logic txNeg,
	input  wire logic corrupt,
	output logic      rxPos,
	output logic      rxNeg
);
	// the stream passes straight back round, inverted only while corrupt is set
	assign rxPos = txPos ^ corrupt;
	assign rxNeg = txNeg ^ corrupt;
endmodule : ring_chain_model

/* File: testbench/ring_io_bus_master_props.sv */
// Purpose: port checks for the ring master
// Assumes: one clock domain
// Notes: bit time spans are checked only in part
`timescale 1ns/1ps
module ring_io_bus_master_props
	import ring_master_pkg::*;
(
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        runMode,
	input wire logic [8:0]  numWords,
	input wire word_wr_t    wordWr,
	input wire logic [7:0]  inRdAddr,
	input wire logic [15:0] inRdData,
	input wire logic        ring_tx_pos,
	input wire logic        ring_tx_neg,
	input wire logic        ring_rx_pos,
	input wire logic        ring_rx_neg,
	input wire logic        cycleDone,
	input wire logic        crcError,
	input wire logic        fallbackActive
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// reset itself must idle the line, so no disable here
	reset_idle_a:
	assert property (disable iff (1'b0) srst |=> !ring_tx_pos && ring_tx_neg)
		else $error("tx not idle after reset");
	diff_pair_a:
	assert property (ring_tx_neg == !ring_tx_pos) else $error("tx pair");
	bit_hold_a:
	assert property ($changed(ring_tx_pos) |=> $stable(ring_tx_pos)[*8])
		else $error("tx bit too short");
	done_pulse_a:
	assert property (cycleDone |=> !cycleDone[*8]) else $error("done pulse");
	done_midbit_a:
	assert property (cycleDone |-> $stable(ring_tx_pos)) else $error("done");
	idle_gap_a:
	assert property (cycleDone |-> ##[95:106] !ring_tx_pos)
		else $error("no idle bit");
	err_hold_a:
	assert property ($changed(crcError) |-> cycleDone) else $error("crc flag");
	fall_stop_a:
	assert property (fallbackActive |-> !runMode) else $error("fallback");
	cover property (cycleDone && !crcError);
	cover property ($rose(crcError));
	cover property ($rose(fallbackActive));
endmodule : ring_io_bus_master_props

/* File: testbench/testbench.sv */
// Purpose: self-checking bench for the ring master
// Assumes: loopback chain, two words per frame
// Notes: frames take about 9800 cycles each
`timescale 1ns/1ps
module testbench
	import ring_master_pkg::*;
;
	logic clk, srst, runMode, corrupt, txP, txN, rxP, rxN, done, err, fbAct;
	logic [8:0]  numWords;
	logic [7:0]  inRdAddr;
	logic [15:0] inRdData;
	word_wr_t    wordWr;
	int          num_errors = 0;
	int          checked = 0;
	ring_io_bus_master DUT (.clk(clk), .srst(srst), .runMode(runMode),
		.numWords(numWords), .wordWr(wordWr), .inRdAddr(inRdAddr),
		.inRdData(inRdData), .ring_tx_pos(txP), .ring_tx_neg(txN),
		.ring_rx_pos(rxP), .ring_rx_neg(rxN), .cycleDone(done),
		.crcError(err), .fallbackActive(fbAct));
	ring_chain_model chain (.txPos(txP), .txNeg(txN), .corrupt(corrupt),
		.rxPos(rxP), .rxNeg(rxN));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic summarize();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: %h vs %h", $time, got, exp);
		end
	endtask : check
	// bounded wait on frame end (0) or fallback start (1)
	task automatic await(input bit sel);
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end while ((sel ? fbAct : done) !== 1'b1 && n < 20000);
		if (n >= 20000)
		begin
			num_errors++;
			summarize();
		end
	endtask : await
	task automatic put(input logic fb, input logic [7:0] a,
		input logic [15:0] d);
		@(posedge clk);
		#1 wordWr = '{1'b1, fb, a, d};
		@(posedge clk);
		#1 wordWr.wr = 1'b0;
	endtask : put
	// run with an empty stream must leave the line idle
	task automatic t_idle();
		runMode = 1'b1;
		repeat (1000) @(posedge clk);
		check({15'h0, txP}, 16'h0);
	endtask : t_idle
	// two words so the word index and image reload are exercised
	task automatic t_loop();
		put(1'b0, 8'h00, 16'ha53c);
		put(1'b0, 8'h01, 16'h5a5a);
		numWords = 9'h002;
		await(1'b0);
		check({15'h0, err}, 16'h0);
		check({15'h0, fbAct}, 16'h0);
		repeat (4) @(posedge clk);
		#1 check(inRdData, 16'ha53c);
		inRdAddr = 8'h01;
		@(posedge clk);
		#1 check(inRdData, 16'h5a5a);
		inRdAddr = 8'h00;
	endtask : t_loop
	// a bad frame keeps the old inputs and raises the flag
	// the bad frame carries a new value, which must not land
	task automatic t_corrupt();
		put(1'b0, 8'h00, 16'h5ac3);
		await(1'b0);
		corrupt = 1'b1;
		put(1'b0, 8'h00, 16'h3cc3);
		await(1'b0);
		repeat (4) @(posedge clk);
		#1 check({15'h0, err}, 16'h1);
		check(inRdData, 16'h5ac3);
	endtask : t_corrupt
	task automatic t_fallback();
		corrupt = 1'b0;
		put(1'b1, 8'h00, 16'h0ff0);
		put(1'b1, 8'h01, 16'hf00f);
		await(1'b0);
		runMode = 1'b0;
		await(1'b1);
		await(1'b0);
		repeat (4) @(posedge clk);
		#1 check({15'h0, err}, 16'h0);
		check(inRdData, 16'h0ff0);
		inRdAddr = 8'h01;
		@(posedge clk);
		#1 check(inRdData, 16'hf00f);
		inRdAddr = 8'h00;
	endtask : t_fallback
	initial
	begin
		srst = 1'b1;
		runMode = 1'b0;
		corrupt = 1'b0;
		numWords = 9'h000;
		inRdAddr = 8'h00;
		wordWr = '0;
		repeat (20) @(posedge clk);
		#1 srst = 1'b0;
		t_idle();
		t_loop();
		t_corrupt();
		t_fallback();
		summarize();
	end
endmodule : testbench
bind ring_io_bus_master ring_io_bus_master_props props (.clk(clk),
	.srst(srst), .runMode(runMode), .numWords(numWords), .wordWr(wordWr),
	.inRdAddr(inRdAddr), .inRdData(inRdData), .ring_tx_pos(ring_tx_pos),
	.ring_tx_neg(ring_tx_neg), .ring_rx_pos(ring_rx_pos),
	.ring_rx_neg(ring_rx_neg), .cycleDone(cycleDone),
	.crcError(crcError), .fallbackActive(fallbackActive));
